/* twa_read_assembler.sv */
// How it works
// - Formatter enabled while drive occupied is asserted
// - Drive set starts motion; delay end initialises
// - Steering start values from format and direction
// - Decode format codes 1100, 1101, 1110
// - Other format codes raise format error
// - First steering bit clear, toggles packed only
// - Second steering bit toggles, every other load if packed; start by mode/direction
// - Each strobe loads low or high latches
// - Steering advances after every latch load
// - Words are 18 bits, top two forced one
// - Load order per mode; reverse starts opposite
// - Packed mode reverse reassembly not guaranteed
// - Parity bit travels with each word
// - Complete word sets transfer flop, 1us sync
// - Sync clears transfer flop; cycle repeats
// - Delay done gives 390ns strobe, latches char
`timescale 1ns/10ps
`default_nettype none

module twa_read_assembler #(
    parameter int CHAR_STROBE_CYCLES = twa_pkg::CHAR_STROBE_CYC,
    parameter int SYNC_CYCLES        = twa_pkg::SYNC_CYC
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    input  wire logic                        clk_en,
    // AHB-Lite slave
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output var  logic                        hreadyout,
    output var  logic [31:0]                 hrdata,
    output var  logic                        hresp,
    // Drive side
    input  wire logic                        drive_occupied,
    input  wire logic                        drive_set_pulse,
    input  wire logic                        motion_delay_end,
    input  wire logic                        strobe_delay_done,
    input  wire logic [twa_pkg::CHAR_W-1:0]  read_char_lines,
    output var  logic                        tape_motion_go,
    output var  logic                        formatter_enable,
    output var  logic                        formatter_init_pulse,
    output var  logic                        format_error,
    output var  logic                        enable_char_strobe,
    // Host controller side
    output var  logic [twa_pkg::WORD_W-1:0]  data_word,
    output var  logic                        word_parity_bit,
    output var  logic                        transfer_pending_ff,
    output var  logic                        word_sync
);

    if (CHAR_STROBE_CYCLES < 1 || CHAR_STROBE_CYCLES > 255) begin : g_bad_strobe
        $error("CHAR_STROBE_CYCLES out of range 1..255");
    end
    if (SYNC_CYCLES < 1 || SYNC_CYCLES > 1023) begin : g_bad_sync
        $error("SYNC_CYCLES out of range 1..1023");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic fmt_valid(input logic [3:0] f);
        fmt_valid = (f == twa_pkg::TWA_FMT_PAIR) || (f == twa_pkg::TWA_FMT_PACKED)
                 || (f == twa_pkg::TWA_FMT_ALT);
    endfunction : fmt_valid

    function automatic logic reg_hit(input logic [31:0] a, input logic [7:0] off);
        reg_hit = (a[twa_pkg::ADDR_DECODE_W-1:0] == off);
    endfunction : reg_hit

    ////////////////////////////////////////////////////////////////////////////
    // Register bus

    logic [4:0]                          ctrl_reg;
    logic                                wr_pend_reg;
    logic [7:0]                          wr_addr_reg;
    logic [twa_pkg::WORD_COUNT_W-1:0]    word_count_reg;
    logic                                running_reg;

    wire        addr_phase = hsel & htrans[1] & hready;
    wire        wr_ctrl    = wr_pend_reg & (wr_addr_reg == twa_pkg::CTRL_OFFSET);
    wire [4:0]  ctrl_next  = wr_ctrl ? hwdata[4:0] : ctrl_reg;
    wire [3:0]  fmt_field  = ctrl_reg[twa_pkg::CTRL_FMT_LSB +: twa_pkg::CTRL_FMT_W];
    wire        reverse    = ctrl_reg[twa_pkg::CTRL_REV_BIT];

    wire [31:0] status_word = {27'h0000000,
                               running_reg,
                               tape_motion_go,
                               transfer_pending_ff,
                               formatter_enable,
                               format_error};

    wire [31:0] rd_mux =
        reg_hit(haddr, twa_pkg::CTRL_OFFSET)   ? {27'h0000000, ctrl_next} :
        reg_hit(haddr, twa_pkg::STATUS_OFFSET) ? status_word :
        reg_hit(haddr, twa_pkg::WORD_OFFSET)   ? {13'h0000, word_parity_bit, data_word} :
        reg_hit(haddr, twa_pkg::COUNT_OFFSET)  ? {16'h0000, word_count_reg} :
                                                 32'h00000000;

    // Zero wait states; read data captured at the address phase edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            hrdata      <= 32'h00000000;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            ctrl_reg    <= twa_pkg::CTRL_RESET;
        end else if (clk_en) begin
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            ctrl_reg    <= ctrl_next;
            wr_pend_reg <= addr_phase & hwrite;
            if (addr_phase) begin
                wr_addr_reg <= haddr[7:0];
            end
            if (addr_phase && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable, motion start and initialisation

    logic mde_q_reg;
    logic sdd_q_reg;
    logic fmt_ok;

    wire init_now = formatter_enable & mde_q_reg & ~motion_delay_end;
    assign fmt_ok = fmt_valid(fmt_field);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            formatter_enable     <= 1'b0;
            tape_motion_go       <= 1'b0;
            formatter_init_pulse <= 1'b0;
            format_error         <= 1'b0;
            running_reg          <= 1'b0;
            mde_q_reg            <= 1'b0;
            sdd_q_reg            <= 1'b0;
        end else if (clk_en) begin
            formatter_enable     <= drive_occupied;
            mde_q_reg            <= motion_delay_end;
            sdd_q_reg            <= strobe_delay_done;
            formatter_init_pulse <= init_now;
            format_error         <= drive_occupied & ~fmt_ok;
            if (!formatter_enable) begin
                tape_motion_go <= 1'b0;
                running_reg    <= 1'b0;
            end else begin
                if (drive_set_pulse) begin
                    tape_motion_go <= 1'b1;
                end
                if (init_now) begin
                    running_reg <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Character strobe

    logic [twa_pkg::CHAR_W-1:0] char_reg;
    logic                       read_strobe;

    wire sdd_rise = formatter_enable & strobe_delay_done & ~sdd_q_reg;

    twa_pulse #(
        .WIDTH_CYCLES (CHAR_STROBE_CYCLES),
        .CNT_W        (8)
    ) u_char_strobe (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .trigger (sdd_rise),
        .active  (enable_char_strobe),
        .done    (read_strobe)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            char_reg <= '0;
        end else if (clk_en && sdd_rise && !enable_char_strobe) begin
            char_reg <= read_char_lines;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Steering and read latches

    logic                         sel_a_reg;
    logic                         sel_b_reg;
    logic [twa_pkg::NIBBLE_W-1:0] latch_reg [4];
    logic [2:0]                   chars_reg;
    logic                         complete_reg;

    wire packed_mode = (fmt_field == twa_pkg::TWA_FMT_PACKED);
    wire alt_mode    = (fmt_field == twa_pkg::TWA_FMT_ALT);
    wire pair_mode   = ~packed_mode;
    wire accept      = read_strobe & running_reg & ~format_error;
    wire [2:0] chars_per_word = packed_mode ? twa_pkg::CHARS_PACKED : twa_pkg::CHARS_PAIR;
    wire word_last   = (chars_reg == chars_per_word - 3'h1);

    // Latch 0/1 form the high byte of the word, 2/3 the low byte
    wire [3:0] load_vec = {sel_b_reg & (pair_mode | sel_a_reg),
                           sel_b_reg & (pair_mode | ~sel_a_reg),
                           ~sel_b_reg & (pair_mode | sel_a_reg),
                           ~sel_b_reg & (pair_mode | ~sel_a_reg)};

    wire sel_a_next = packed_mode ? ~sel_a_reg : sel_a_reg;
    wire sel_b_next = packed_mode ? (sel_b_reg ^ sel_a_reg) : ~sel_b_reg;
    wire sel_b_init = alt_mode ^ reverse;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel_a_reg    <= 1'b0;
            sel_b_reg    <= 1'b0;
            chars_reg    <= 3'h0;
            complete_reg <= 1'b0;
        end else if (clk_en) begin
            complete_reg <= accept & word_last;
            if (init_now) begin
                sel_a_reg <= 1'b0;
                sel_b_reg <= sel_b_init;
                chars_reg <= 3'h0;
            end else if (accept) begin
                sel_a_reg <= sel_a_next;
                sel_b_reg <= sel_b_next;
                chars_reg <= word_last ? 3'h0 : chars_reg + 3'h1;
            end
        end
    end

    for (genvar i = 0; i < 4; i++) begin : g_latch
        // Even latch takes the high nibble in pair modes
        wire [3:0] nib = (pair_mode && (i % 2 == 0)) ? char_reg[7:4] : char_reg[3:0];
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                latch_reg[i] <= '0;
            end else if (clk_en && accept && load_vec[i]) begin
                latch_reg[i] <= nib;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word hand-off to the host controller

    logic                       sync_start;
    logic [twa_pkg::WORD_W-1:0] staged_word_reg;
    logic                       staged_parity_reg;

    wire [twa_pkg::WORD_W-1:0] word_asm = {twa_pkg::WORD_TOP_BITS,
                                           latch_reg[0], latch_reg[1],
                                           latch_reg[2], latch_reg[3]};

    assign sync_start = transfer_pending_ff & ~word_sync & ~format_error;

    twa_pulse #(
        .WIDTH_CYCLES (SYNC_CYCLES),
        .CNT_W        (10)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .trigger (sync_start),
        .active  (word_sync),
        .done    ()
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_word           <= '0;
            word_parity_bit     <= 1'b1;
            staged_word_reg     <= '0;
            staged_parity_reg   <= 1'b1;
            transfer_pending_ff <= 1'b0;
            word_count_reg      <= '0;
        end else if (clk_en) begin
            // New word wins over the clear from sync
            transfer_pending_ff <= complete_reg | (transfer_pending_ff & ~sync_start);
            if (complete_reg) begin
                staged_word_reg   <= word_asm;
                staged_parity_reg <= ~(^word_asm);
                word_count_reg    <= word_count_reg + 16'h0001;
            end
            // Lines change only as a sync starts, never under one
            if (sync_start) begin
                data_word       <= staged_word_reg;
                word_parity_bit <= staged_parity_reg;
            end
        end
    end

endmodule : twa_read_assembler

`default_nettype wire

/* twa_pkg.sv */
package twa_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET      = 8'h00;
    localparam logic [7:0] STATUS_OFFSET    = 8'h04;
    localparam logic [7:0] WORD_OFFSET      = 8'h08;
    localparam logic [7:0] COUNT_OFFSET     = 8'h0c;
    localparam int         ADDR_DECODE_W    = 8;

    // Control register fields
    localparam int         CTRL_FMT_LSB     = 0;
    localparam int         CTRL_FMT_W       = 4;
    localparam int         CTRL_REV_BIT     = 4;
    localparam logic [4:0] CTRL_RESET       = 5'h00;

    // Status register fields
    localparam int         STAT_FMT_ERR_BIT = 0;
    localparam int         STAT_ENABLE_BIT  = 1;
    localparam int         STAT_XFER_BIT    = 2;
    localparam int         STAT_MOTION_BIT  = 3;
    localparam int         STAT_RUN_BIT     = 4;

    // Word layout
    localparam int         CHAR_W           = 8;
    localparam int         NIBBLE_W         = 4;
    localparam int         WORD_W           = 18;
    localparam logic [1:0] WORD_TOP_BITS    = 2'h3;
    localparam int         WORD_COUNT_W     = 16;

    // Format codes
    typedef enum logic [3:0] {
        TWA_FMT_PAIR   = 4'b1100,
        TWA_FMT_PACKED = 4'b1101,
        TWA_FMT_ALT    = 4'b1110
    } twa_fmt_e;

    localparam logic [2:0] CHARS_PAIR       = 3'h2;
    localparam logic [2:0] CHARS_PACKED     = 3'h4;

    // Timing
    localparam int         CLK_MHZ          = 200;
    localparam int         CHAR_STROBE_NS   = 390;
    localparam int         SYNC_NS          = 1000;
    localparam int         CHAR_STROBE_CYC  = (CHAR_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int         SYNC_CYC         = (SYNC_NS * CLK_MHZ) / 1000;

endpackage : twa_pkg

/* twa_pulse.sv */
`timescale 1ns/10ps
`default_nettype none

module twa_pulse #(
    parameter int WIDTH_CYCLES = 8,
    parameter int CNT_W        = 8
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic trigger,
    output var  logic active,
    output var  logic done
);

    if (WIDTH_CYCLES < 1 || WIDTH_CYCLES >= (1 << CNT_W)) begin : g_bad_width
        $error("twa_pulse width does not fit its counter");
    end

    localparam logic [CNT_W-1:0] LAST = CNT_W'(WIDTH_CYCLES - 1);

    logic [CNT_W-1:0] cnt_reg;
    wire              start = trigger & ~active;
    wire              last  = active & (cnt_reg == LAST);

    // Retrigger while active is ignored
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            active  <= 1'b0;
            done    <= 1'b0;
            cnt_reg <= '0;
        end else if (clk_en) begin
            done    <= last;
            cnt_reg <= start ? '0 : cnt_reg + CNT_W'(1);
            if (start) begin
                active <= 1'b1;
            end else if (last) begin
                active <= 1'b0;
            end
        end
    end

endmodule : twa_pulse

`default_nettype wire

/* twa_read_assembler_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module twa_read_assembler_properties #(
    parameter int CHAR_STROBE_CYCLES = 78,
    parameter int SYNC_CYCLES        = 200
) (
    input wire logic                       clk_sys,
    input wire logic                       rst_n,
    input wire logic                       clk_en,
    input wire logic                       drive_occupied,
    input wire logic                       drive_set_pulse,
    input wire logic                       motion_delay_end,
    input wire logic                       strobe_delay_done,
    input wire logic                       tape_motion_go,
    input wire logic                       formatter_enable,
    input wire logic                       formatter_init_pulse,
    input wire logic                       format_error,
    input wire logic                       enable_char_strobe,
    input wire logic [twa_pkg::WORD_W-1:0] data_word,
    input wire logic                       word_parity_bit,
    input wire logic                       transfer_pending_ff,
    input wire logic                       word_sync
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [15:0] strobe_cnt_reg;
    logic [15:0] sync_cnt_reg;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strobe_cnt_reg <= 16'h0000;
            sync_cnt_reg   <= 16'h0000;
        end else if (clk_en) begin
            strobe_cnt_reg <= enable_char_strobe ? strobe_cnt_reg + 16'h0001 : 16'h0000;
            sync_cnt_reg   <= word_sync ? sync_cnt_reg + 16'h0001 : 16'h0000;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_enable; clk_en |=> formatter_enable == $past(drive_occupied); endproperty
    a_enable: assert property (p_enable) else $error("enable does not follow occupied");
    property p_motion; drive_set_pulse && formatter_enable && clk_en |-> ##[1:2] tape_motion_go;
    endproperty
    a_motion: assert property (p_motion) else $error("motion not started");
    property p_init; $fell(motion_delay_end) && formatter_enable && clk_en
        |-> ##[0:2] formatter_init_pulse; endproperty
    a_init: assert property (p_init) else $error("no init pulse");
    property p_init_one; formatter_init_pulse |=> !formatter_init_pulse; endproperty
    a_init_one: assert property (p_init_one) else $error("init pulse too long");
    property p_err_en; format_error |-> formatter_enable; endproperty
    a_err_en: assert property (p_err_en) else $error("format error while disabled");
    property p_strobe_cause; $rose(enable_char_strobe)
        |-> $past(strobe_delay_done) && !$past(strobe_delay_done, 2) && $past(formatter_enable);
    endproperty
    a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without cause");
    property p_strobe_len; $fell(enable_char_strobe) |-> strobe_cnt_reg == 16'(CHAR_STROBE_CYCLES);
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("char strobe width");
    property p_sync_len; $fell(word_sync) |-> sync_cnt_reg == 16'(SYNC_CYCLES); endproperty
    a_sync_len: assert property (p_sync_len) else $error("sync width");
    property p_xfer; $rose(transfer_pending_ff) && !word_sync |=> word_sync && !transfer_pending_ff;
    endproperty
    a_xfer: assert property (p_xfer) else $error("transfer flop to sync");
    property p_top; word_sync |-> data_word[17:16] == 2'b11 && word_parity_bit == ~^data_word;
    endproperty
    a_top: assert property (p_top) else $error("word top bits or parity");
    property p_hold; word_sync ##1 word_sync |-> $stable(data_word); endproperty
    a_hold: assert property (p_hold) else $error("word moved during sync");
    property p_err_sync; $rose(word_sync) |-> !format_error; endproperty
    a_err_sync: assert property (p_err_sync) else $error("sync despite format error");
endmodule : twa_read_assembler_properties
bind twa_read_assembler twa_read_assembler_properties #(.CHAR_STROBE_CYCLES(CHAR_STROBE_CYCLES),
    .SYNC_CYCLES(SYNC_CYCLES)) i_twa_read_assembler_properties (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(clk_en), .drive_occupied(drive_occupied), .drive_set_pulse(drive_set_pulse),
    .motion_delay_end(motion_delay_end), .strobe_delay_done(strobe_delay_done),
    .tape_motion_go(tape_motion_go), .formatter_enable(formatter_enable),
    .formatter_init_pulse(formatter_init_pulse), .format_error(format_error),
    .enable_char_strobe(enable_char_strobe), .data_word(data_word),
    .word_parity_bit(word_parity_bit), .transfer_pending_ff(transfer_pending_ff),
    .word_sync(word_sync));
`default_nettype wire

/* twa_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module twa_host_model (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic                       word_sync,
    input  wire logic [twa_pkg::WORD_W-1:0] data_word,
    input  wire logic                       word_parity_bit,
    output var  logic                       got_valid,
    output var  logic [twa_pkg::WORD_W:0]   got_word
);
    logic sync_prev_reg;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_prev_reg <= 1'b0;
            got_valid     <= 1'b0;
            got_word      <= '0;
        end else begin
            sync_prev_reg <= word_sync;
            got_valid     <= word_sync && !sync_prev_reg;
            if (word_sync && !sync_prev_reg) begin
                got_word <= {word_parity_bit, data_word};
            end
        end
    end
endmodule : twa_host_model
`default_nettype wire

/* twa_read_assembler_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module twa_read_assembler_tb;
    logic        clk_sys, rst_n, clk_en, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, seed, c, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        drive_occupied, drive_set_pulse, motion_delay_end, strobe_delay_done;
    logic [7:0]  read_char_lines;
    logic [17:0] data_word;
    logic [18:0] got_word, e;
    logic        word_parity_bit, transfer_pending_ff, word_sync, got_valid;
    logic [3:0]  fmts [3];
    logic [18:0] exp_q [$];
    int          n_errors, n_checks, cycles, nchar;
    twa_read_assembler #(.CHAR_STROBE_CYCLES(4), .SYNC_CYCLES(8)) i_twa_read_assembler (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .drive_occupied(drive_occupied),
        .drive_set_pulse(drive_set_pulse), .motion_delay_end(motion_delay_end),
        .strobe_delay_done(strobe_delay_done), .read_char_lines(read_char_lines),
        .tape_motion_go(), .formatter_enable(), .formatter_init_pulse(), .format_error(),
        .enable_char_strobe(), .data_word(data_word), .word_parity_bit(word_parity_bit),
        .transfer_pending_ff(transfer_pending_ff), .word_sync(word_sync));
    twa_host_model i_twa_host_model (.clk_sys(clk_sys), .rst_n(rst_n), .word_sync(word_sync),
        .data_word(data_word), .word_parity_bit(word_parity_bit), .got_valid(got_valid),
        .got_word(got_word));
    always #2.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    function automatic logic [18:0] exp_word(input logic [3:0] f, input logic r,
                                             input logic [31:0] ch);
        logic [15:0] w;
        if (f == twa_pkg::TWA_FMT_PACKED) begin
            w = r ? {ch[19:16], ch[27:24], ch[3:0], ch[11:8]}
                  : {ch[3:0], ch[11:8], ch[19:16], ch[27:24]};
        end else if ((f == twa_pkg::TWA_FMT_ALT) ^ r) begin
            w = {ch[15:8], ch[7:0]};
        end else begin
            w = {ch[7:0], ch[15:8]};
        end
        return {~^{2'b11, w}, 2'b11, w};
    endfunction : exp_word
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chk_reg(input string n, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask : chk_reg
    task automatic chk_word(input logic [18:0] x, input logic [18:0] g);
        n_checks++;
        if (g !== x) begin
            n_errors++;
            $display("wrong value data_word expected %h seen %h", x, g);
        end
    endtask : chk_word
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb
    task automatic send_char(input logic [7:0] ch);
        read_char_lines   <= ch;
        strobe_delay_done <= 1'b1;
        repeat (2) @(posedge clk_sys);
        strobe_delay_done <= 1'b0;
        read_char_lines   <= ~ch;
        repeat (20) @(posedge clk_sys);
    endtask : send_char
    task automatic start(input logic [4:0] ctl);
        ahb(1'b1, twa_pkg::CTRL_OFFSET, {27'h0, ctl}, rd);
        ahb(1'b0, twa_pkg::CTRL_OFFSET, 32'h0, rd);
        chk_reg("ctrl", {27'h0, ctl}, rd);
        drive_occupied <= 1'b1;
        repeat (2) @(posedge clk_sys);
        drive_set_pulse <= 1'b1;
        @(posedge clk_sys);
        drive_set_pulse  <= 1'b0;
        motion_delay_end <= 1'b1;
        repeat (3) @(posedge clk_sys);
        motion_delay_end <= 1'b0;
        repeat (4) @(posedge clk_sys);
        ahb(1'b0, twa_pkg::STATUS_OFFSET, 32'h0, rd);
    endtask : start
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
        if (got_valid === 1'b1) begin
            if (exp_q.size() == 0) chk_word(19'h0, got_word);
            else chk_word(exp_q.pop_front(), got_word);
        end
    end
    initial begin
        {clk_sys, rst_n, hsel, hwrite, htrans, haddr, hwdata, cycles, n_errors, n_checks} = '0;
        {drive_occupied, drive_set_pulse, motion_delay_end, strobe_delay_done} = '0;
        {clk_en, hsize, read_char_lines, seed} = {1'b1, 3'h2, 8'h00, 32'h3baf};
        fmts = '{twa_pkg::TWA_FMT_PAIR, twa_pkg::TWA_FMT_PACKED, twa_pkg::TWA_FMT_ALT};
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        ahb(1'b1, 8'h10, 32'hffffffff, rd);
        ahb(1'b1, twa_pkg::STATUS_OFFSET, 32'hffffffff, rd);
        for (int a = 0; a < 20; a += 4) begin
            ahb(1'b0, 8'(a), 32'h0, rd);
            chk_reg("reset", (a == 8) ? 32'h00040000 : 32'h0, rd);
        end
        for (int m = 0; m < 6; m++) begin
            start({m[0], fmts[m/2]});
            chk_reg("status", 32'h1a, rd);
            nchar = (fmts[m/2] == twa_pkg::TWA_FMT_PACKED) ? 4 : 2;
            for (int w = 0; w < 2; w++) begin
                seed = xorshift(seed);
                c    = seed;
                e    = exp_word(fmts[m/2], m[0], c);
                exp_q.push_back(e);
                for (int k = 0; k < nchar; k++) send_char(c[8*k +: 8]);
            end
            ahb(1'b0, twa_pkg::WORD_OFFSET, 32'h0, rd);
            chk_reg("word", {13'h0, e}, rd);
            ahb(1'b0, twa_pkg::COUNT_OFFSET, 32'h0, rd);
            chk_reg("count", 32'(2 * m + 2), rd);
            drive_occupied <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
        start(5'h03);
        chk_reg("status_err", 32'h3, rd & 32'h3);
        for (int k = 0; k < 4; k++) send_char(8'h5a);
        chk_reg("leftover", 32'(exp_q.size()), 32'h0);
        drive_occupied <= 1'b0;
        repeat (2) @(posedge clk_sys);
        ahb(1'b0, twa_pkg::STATUS_OFFSET, 32'h0, rd);
        chk_reg("status_off", 32'h0, rd);
        stop_test();
    end
endmodule : twa_read_assembler_tb
`default_nettype wire
